/* design/qsa_pkg.sv */
// ****************************************************************
// Register map, field layout and reset values
// ****************************************************************
package qsa_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] ADDR_QUES_EVENT = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_QUES_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_INST_EVENT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_INST_ENABLE = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_PRESET = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_CH_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h10;
	localparam logic [ADDR_W-1:0] CH_OFS_EVENT = 8'h00;
	localparam logic [ADDR_W-1:0] CH_OFS_COND = 8'h04;
	localparam logic [ADDR_W-1:0] CH_OFS_ENABLE = 8'h08;

	localparam int CH_COUNT = 3;
	localparam int QUES_W = 16;
	localparam int INST_W = 16;
	localparam int CH_EV_W = 3;
	localparam int COND_W = 2;
	localparam int INT_W = 3;
	localparam int INSTRUMENT_SUMMARY_BIT = 13;
	localparam int INST_CH_LSB = 1;

	localparam int EV_CURRENT = 0;
	localparam int EV_VOLTAGE = 1;
	localparam int EV_FAIL = 2;
	localparam int INT_QUES = 0;
	localparam int INT_INST = 1;
	localparam int INT_SUMMARY = 2;

	localparam logic [QUES_W-1:0] QUES_ENABLE_RST = 16'h0000;
	localparam logic [INST_W-1:0] INST_ENABLE_RST = 16'h0000;
	localparam logic [CH_EV_W-1:0] CH_ENABLE_RST = 3'h0;
	localparam logic [INT_W-1:0] INT_ENABLE_RST = 3'h0;

	typedef enum logic [COND_W-1:0] {
		COND_OFF = 2'h0,
		COND_CURRENT = 2'h1,
		COND_VOLTAGE = 2'h2,
		COND_FAIL = 2'h3
	} cond_t;
endpackage : qsa_pkg

/* design/output_summary_channel.sv */
`timescale 1ns/1ns
// ****************************************************************
// One output: condition code and latched summary events
// ****************************************************************
module output_summary_channel import qsa_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic current_regulated_state,
	input wire logic voltage_regulated_state,
	input wire logic hw_fail,
	input wire logic [CH_EV_W-1:0] enable_mask,
	input wire logic [CH_EV_W-1:0] clear_mask,
	output logic [CH_EV_W-1:0] event_reg,
	output logic [CH_EV_W-1:0] event_set,
	output cond_t cond,
	output logic summary
);
	logic [CH_EV_W-1:0] level;
	logic [CH_EV_W-1:0] level_prev_reg;

	// Failure outranks regulation; voltage outranks current if both claimed
	always_comb begin
		if (hw_fail) begin
			cond = COND_FAIL;
		end else if (voltage_regulated_state) begin
			cond = COND_VOLTAGE;
		end else if (current_regulated_state) begin
			cond = COND_CURRENT;
		end else begin
			cond = COND_OFF;
		end
	end

	always_comb begin
		level = '0;
		level[EV_CURRENT] = current_regulated_state;
		level[EV_VOLTAGE] = voltage_regulated_state;
		level[EV_FAIL] = hw_fail;
	end

	assign event_set = level & ~level_prev_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_prev_reg <= '0;
		end else begin
			level_prev_reg <= level;
		end
	end

	// A new event beats the read clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			event_reg <= '0;
		end else begin
			event_reg <= (event_reg & ~clear_mask) | event_set;
		end
	end

	assign summary = |(event_reg & enable_mask);
endmodule : output_summary_channel

/* design/questionable_status_aggregator.sv */
`timescale 1ns/1ns
// Summary of operation
// - A preset write restores every questionable enable mask to its reset value.
// - Questionable event read returns the register as a binary-weighted value.
// - Status byte summary is the OR of questionable events gated by enable.
// - Instrument event read returns its value and clears the bits read.
// - Bit 13 condition is OR of instrument events masked by instrument enable.
// - Each of three outputs keeps its own latching summary event register.
// - Software writes never change per-output summary event registers.
// - Reading a per-output summary event register clears it.
// - Condition code: 0 off, 1 current, 2 voltage regulated, 3 failure.
// - Per-output enable gates its events into an OR driving instrument bits 1-3.
// - Instrument enable mask is writable and reads back the value written.
module questionable_status_aggregator import qsa_pkg::*; #(
	parameter int CH_N = CH_COUNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [QUES_W-1:0] ques_cond_in,
	input wire logic [CH_N-1:0] current_regulated_state,
	input wire logic [CH_N-1:0] voltage_regulated_state,
	input wire logic [CH_N-1:0] hw_fail,
	output logic ques_summary,
	output logic irq
);
	// ****************************************************************
	// Bus handshake
	// ****************************************************************
	logic acc_first;
	logic acc_done;
	logic wr_done;
	logic rd_done;
	logic [DATA_W-1:0] rdata_next;
	logic hit_next;

	// One wait state: data is sampled in the first access cycle
	assign acc_first = psel & penable & ~pready;
	assign acc_done = psel & penable & pready;
	assign wr_done = acc_done & pwrite;
	assign rd_done = acc_done & ~pwrite;

	// ****************************************************************
	// Status state
	// ****************************************************************
	logic [QUES_W-1:0] ques_event_reg;
	logic [QUES_W-1:0] ques_enable_reg;
	logic [QUES_W-1:0] ques_cond;
	logic [QUES_W-1:0] ques_prev_reg;
	logic [QUES_W-1:0] ques_set;
	logic [QUES_W-1:0] ques_clr;
	logic [INST_W-1:0] inst_event_reg;
	logic [INST_W-1:0] inst_enable_reg;
	logic [INST_W-1:0] inst_set;
	logic [INST_W-1:0] inst_clr;
	logic [CH_N-1:0] ch_sum_prev_reg;
	logic [CH_N-1:0][CH_EV_W-1:0] ch_enable_reg;
	logic [CH_N-1:0][CH_EV_W-1:0] ch_event;
	logic [CH_N-1:0][CH_EV_W-1:0] ch_set;
	logic [CH_N-1:0][CH_EV_W-1:0] ch_clr;
	cond_t ch_cond [CH_N];
	logic [CH_N-1:0] ch_summary;
	logic [CH_N-1:0][ADDR_W-1:0] ch_base;
	logic [INT_W-1:0] int_status_reg;
	logic [INT_W-1:0] int_enable_reg;
	logic [INT_W-1:0] int_set;
	logic [INT_W-1:0] int_clr;
	logic preset_hit;

	assign preset_hit = wr_done && (paddr == ADDR_PRESET);

	// ****************************************************************
	// Per-output summary channels
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < CH_N; gi++) begin : g_ch
			assign ch_base[gi] = ADDR_W'(ADDR_CH_BASE + CH_STRIDE * gi);
			// Only the bits actually returned are cleared, so nothing set after
			// the data was sampled is lost
			assign ch_clr[gi] = (rd_done && paddr == ch_base[gi] + CH_OFS_EVENT) ?
				prdata[CH_EV_W-1:0] : '0;
			output_summary_channel i_output_summary_channel (
				.clk(pclk),
				.rst_n(presetn),
				.current_regulated_state(current_regulated_state[gi]),
				.voltage_regulated_state(voltage_regulated_state[gi]),
				.hw_fail(hw_fail[gi]),
				.enable_mask(ch_enable_reg[gi]),
				.clear_mask(ch_clr[gi]),
				.event_reg(ch_event[gi]),
				.event_set(ch_set[gi]),
				.cond(ch_cond[gi]),
				.summary(ch_summary[gi])
			);
			assign inst_set[INST_CH_LSB+gi] = ch_summary[gi] & ~ch_sum_prev_reg[gi];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ch_enable_reg[gi] <= CH_ENABLE_RST;
				end else if (preset_hit) begin
					ch_enable_reg[gi] <= CH_ENABLE_RST;
				end else if (wr_done && paddr == ch_base[gi] + CH_OFS_ENABLE) begin
					ch_enable_reg[gi] <= pwdata[CH_EV_W-1:0];
				end
			end
		end
		for (gi = 0; gi < INST_W; gi++) begin : g_unused
			if (gi < INST_CH_LSB || gi >= INST_CH_LSB + CH_N) begin : g_zero
				assign inst_set[gi] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_sum_prev_reg <= '0;
		end else begin
			ch_sum_prev_reg <= ch_summary;
		end
	end

	// ****************************************************************
	// Instrument event and enable
	// ****************************************************************
	assign inst_clr = (rd_done && paddr == ADDR_INST_EVENT) ? prdata[INST_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inst_event_reg <= '0;
		end else begin
			inst_event_reg <= (inst_event_reg & ~inst_clr) | inst_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inst_enable_reg <= INST_ENABLE_RST;
		end else if (preset_hit) begin
			inst_enable_reg <= INST_ENABLE_RST;
		end else if (wr_done && paddr == ADDR_INST_ENABLE) begin
			inst_enable_reg <= pwdata[INST_W-1:0];
		end
	end

	// ****************************************************************
	// Questionable event, enable and status byte summary
	// ****************************************************************
	always_comb begin
		ques_cond = ques_cond_in;
		ques_cond[INSTRUMENT_SUMMARY_BIT] = |(inst_event_reg & inst_enable_reg);
	end

	assign ques_set = ques_cond & ~ques_prev_reg;
	assign ques_clr = (rd_done && paddr == ADDR_QUES_EVENT) ? prdata[QUES_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ques_prev_reg <= '0;
			ques_event_reg <= '0;
		end else begin
			ques_prev_reg <= ques_cond;
			ques_event_reg <= (ques_event_reg & ~ques_clr) | ques_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ques_enable_reg <= QUES_ENABLE_RST;
		end else if (preset_hit) begin
			ques_enable_reg <= QUES_ENABLE_RST;
		end else if (wr_done && paddr == ADDR_QUES_ENABLE) begin
			ques_enable_reg <= pwdata[QUES_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ques_summary <= 1'b0;
		end else begin
			ques_summary <= |(ques_event_reg & ques_enable_reg);
		end
	end

	// ****************************************************************
	// Interrupt status, clear and enable
	// ****************************************************************
	always_comb begin
		int_set = '0;
		int_set[INT_QUES] = |ques_set;
		int_set[INT_INST] = |inst_set;
		int_set[INT_SUMMARY] = |(ques_event_reg & ques_enable_reg) & ~ques_summary;
	end

	assign int_clr = (wr_done && paddr == ADDR_INT_CLEAR) ? pwdata[INT_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status_reg <= '0;
		end else begin
			int_status_reg <= (int_status_reg & ~int_clr) | int_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_enable_reg <= INT_ENABLE_RST;
		end else if (wr_done && paddr == ADDR_INT_ENABLE) begin
			int_enable_reg <= pwdata[INT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_reg & int_enable_reg);
		end
	end

	// ****************************************************************
	// Read mux and bus answer
	// ****************************************************************
	always_comb begin
		rdata_next = '0;
		hit_next = 1'b1;
		unique case (paddr)
			ADDR_QUES_EVENT: rdata_next[QUES_W-1:0] = ques_event_reg;
			ADDR_QUES_ENABLE: rdata_next[QUES_W-1:0] = ques_enable_reg;
			ADDR_INST_EVENT: rdata_next[INST_W-1:0] = inst_event_reg;
			ADDR_INST_ENABLE: rdata_next[INST_W-1:0] = inst_enable_reg;
			ADDR_INT_STATUS: rdata_next[INT_W-1:0] = int_status_reg;
			ADDR_INT_ENABLE: rdata_next[INT_W-1:0] = int_enable_reg;
			ADDR_PRESET, ADDR_INT_CLEAR: rdata_next = '0;
			default: hit_next = 1'b0;
		endcase
		for (int i = 0; i < CH_N; i++) begin
			if (paddr == ch_base[i] + CH_OFS_EVENT) begin
				rdata_next[CH_EV_W-1:0] = ch_event[i];
				hit_next = 1'b1;
			end
			if (paddr == ch_base[i] + CH_OFS_COND) begin
				rdata_next[COND_W-1:0] = ch_cond[i];
				hit_next = 1'b1;
			end
			if (paddr == ch_base[i] + CH_OFS_ENABLE) begin
				rdata_next[CH_EV_W-1:0] = ch_enable_reg[i];
				hit_next = 1'b1;
			end
		end
	end

	// Writes to event and condition offsets are accepted and dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (acc_first) begin
			pready <= 1'b1;
			pslverr <= ~hit_next;
			prdata <= pwrite ? '0 : rdata_next;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [CH_N*CH_EV_W-1:0] ch_event_flat;
	assign ch_event_flat = ch_event;

	sequence s_rd_setup(logic [ADDR_W-1:0] a);
		acc_first && !pwrite && paddr == a;
	endsequence

	property p_preset;
		preset_hit |=> ques_enable_reg == QUES_ENABLE_RST && inst_enable_reg == INST_ENABLE_RST
			&& ch_enable_reg[0] == CH_ENABLE_RST;
	endproperty
	a_preset: assert property (p_preset) else $error("preset left an enable mask set");

	property p_ques_read;
		s_rd_setup(ADDR_QUES_EVENT) |=> pready && prdata[QUES_W-1:0] == $past(ques_event_reg)
			&& prdata[DATA_W-1:QUES_W] == '0;
	endproperty
	a_ques_read: assert property (p_ques_read) else $error("questionable read value wrong");

	property p_summary;
		##1 ques_summary == $past(|(ques_event_reg & ques_enable_reg));
	endproperty
	a_summary: assert property (p_summary) else $error("status summary not gated by enable");

	property p_inst_clear;
		rd_done && paddr == ADDR_INST_EVENT && inst_set == '0
			|=> (inst_event_reg & $past(prdata[INST_W-1:0])) == '0;
	endproperty
	a_inst_clear: assert property (p_inst_clear) else $error("instrument read did not clear");

	property p_inst_summary;
		$rose(|(inst_event_reg & inst_enable_reg)) |=> ques_event_reg[INSTRUMENT_SUMMARY_BIT];
	endproperty
	a_inst_summary: assert property (p_inst_summary) else $error("bit 13 missed summary");

	property p_ch_hold;
		ch_clr == '0 |=> (ch_event_flat & $past(ch_event_flat)) == $past(ch_event_flat);
	endproperty
	a_ch_hold: assert property (p_ch_hold) else $error("summary event dropped without read");

	property p_ch_ro;
		wr_done && paddr == ch_base[0] + CH_OFS_EVENT |=> ch_event[0] == ($past(ch_event[0])
			| $past(ch_set[0]));
	endproperty
	a_ch_ro: assert property (p_ch_ro) else $error("write altered a summary event");

	property p_ch_clear;
		rd_done && paddr == ch_base[0] + CH_OFS_EVENT && ch_set[0] == '0
			|=> (ch_event[0] & $past(prdata[CH_EV_W-1:0])) == '0;
	endproperty
	a_ch_clear: assert property (p_ch_clear) else $error("summary read did not clear");

	property p_cond;
		hw_fail[0] |-> ch_cond[0] == COND_FAIL;
	endproperty
	a_cond: assert property (p_cond) else $error("failure code not reported");

	property p_inst_bit;
		$rose(ch_summary[0]) |=> inst_event_reg[INST_CH_LSB];
	endproperty
	a_inst_bit: assert property (p_inst_bit) else $error("output 1 summary not latched");

	property p_inst_enable;
		wr_done && paddr == ADDR_INST_ENABLE |=> inst_enable_reg == $past(pwdata[INST_W-1:0]);
	endproperty
	a_inst_enable: assert property (p_inst_enable) else $error("instrument enable not stored");

	property p_latch;
		ch_set[0][EV_FAIL] |=> ch_event[0][EV_FAIL] [*2];
	endproperty
	a_latch: assert property (p_latch) else $error("failure event not held");
endmodule : questionable_status_aggregator

/* tb/tb_questionable_status_aggregator.sv */
`timescale 1ns/1ns
module tb_questionable_status_aggregator import qsa_pkg::*; ;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [QUES_W-1:0] ques_cond_in;
	logic [CH_COUNT-1:0] current_regulated_state;
	logic [CH_COUNT-1:0] voltage_regulated_state;
	logic [CH_COUNT-1:0] hw_fail;
	logic ques_summary;
	logic irq;
	int mismatches = 0;
	int cmp_count = 0;

	questionable_status_aggregator #(.CH_N(CH_COUNT)) i_questionable_status_aggregator (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ques_cond_in(ques_cond_in),
		.current_regulated_state(current_regulated_state),
		.voltage_regulated_state(voltage_regulated_state),
		.hw_fail(hw_fail),
		.ques_summary(ques_summary),
		.irq(irq)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ****************************************************************
	// Bus and compare helpers
	// ****************************************************************
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_pin(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_pin

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Request held until pready is sampled high; data taken at that same edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] rd_data, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("mismatch pready expected 1 seen %b", pready);
		end
		rd_data = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input string what, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask : rd

	function automatic logic [ADDR_W-1:0] cha(input int n, input logic [ADDR_W-1:0] ofs);
		return ADDR_CH_BASE + CH_STRIDE * ADDR_W'(n) + ofs;
	endfunction : cha

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		rd("ques_enable", ADDR_QUES_ENABLE, 32'h0);
		rd("inst_enable", ADDR_INST_ENABLE, 32'h0);
		rd("int_enable", ADDR_INT_ENABLE, 32'h0);
		for (int i = 0; i < CH_COUNT; i++) begin
			rd("ch_enable", cha(i, CH_OFS_ENABLE), 32'h0);
		end
		chk_pin("ques_summary", 1'b0, ques_summary);
		chk_pin("irq", 1'b0, irq);
		$display("test reset done");
	endtask : t_reset

	task automatic t_unmapped();
		logic [DATA_W-1:0] r;
		logic e;
		apb(1'b0, 8'hfc, 32'h0, r, e);
		chk("unmapped prdata", 32'h0, r);
		chk_pin("unmapped pslverr", 1'b1, e);
		apb(1'b1, cha(0, CH_OFS_EVENT), 32'h7, r, e);
		chk_pin("read-only write pslverr", 1'b0, e);
		rd("ch_event", cha(0, CH_OFS_EVENT), 32'h0);
		$display("test unmapped done");
	endtask : t_unmapped

	task automatic t_irq();
		wr(ADDR_INT_ENABLE, 32'h1);
		ques_cond_in <= 16'h8014;
		cyc(5);
		chk_pin("irq", 1'b1, irq);
		rd("int_status", ADDR_INT_STATUS, 32'h1);
		rd("ques_event", ADDR_QUES_EVENT, 32'h8014);
		rd("ques_event", ADDR_QUES_EVENT, 32'h0);
		wr(ADDR_INT_CLEAR, 32'h1);
		cyc(3);
		chk_pin("irq", 1'b0, irq);
		rd("int_status", ADDR_INT_STATUS, 32'h0);
		ques_cond_in <= 16'h0000;
		wr(ADDR_INT_ENABLE, 32'h0);
		$display("test irq done");
	endtask : t_irq

	task automatic t_cond();
		logic [2:0] pat [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
		for (int i = 0; i < CH_COUNT; i++) begin
			for (int k = 0; k < 4; k++) begin
				current_regulated_state <= CH_COUNT'(pat[k][0]) << i;
				voltage_regulated_state <= CH_COUNT'(pat[k][1]) << i;
				hw_fail <= CH_COUNT'(pat[k][2]) << i;
				cyc(3);
				rd("ch_cond", cha(i, CH_OFS_COND), DATA_W'(k));
			end
			hw_fail <= '0;
			cyc(3);
			wr(cha(i, CH_OFS_EVENT), 32'h0);
			rd("ch_event", cha(i, CH_OFS_EVENT), 32'h7);
			rd("ch_event", cha(i, CH_OFS_EVENT), 32'h0);
		end
		rd("inst_event", ADDR_INST_EVENT, 32'h0);
		$display("test cond done");
	endtask : t_cond

	task automatic t_chain();
		wr(cha(1, CH_OFS_ENABLE), 32'h4);
		wr(ADDR_INST_ENABLE, 32'h4);
		wr(ADDR_QUES_ENABLE, 32'h2000);
		rd("inst_enable", ADDR_INST_ENABLE, 32'h4);
		current_regulated_state <= 3'b010;
		cyc(6);
		chk_pin("ques_summary", 1'b0, ques_summary);
		hw_fail <= 3'b010;
		cyc(6);
		chk_pin("ques_summary", 1'b1, ques_summary);
		rd("ch_event", cha(1, CH_OFS_EVENT), 32'h5);
		cyc(4);
		rd("inst_event", ADDR_INST_EVENT, 32'h4);
		rd("inst_event", ADDR_INST_EVENT, 32'h0);
		rd("ques_event", ADDR_QUES_EVENT, 32'h2000);
		cyc(4);
		chk_pin("ques_summary", 1'b0, ques_summary);
		current_regulated_state <= '0;
		hw_fail <= '0;
		cyc(3);
		rd("ch_event", cha(1, CH_OFS_EVENT), 32'h0);
		rd("int_status", ADDR_INT_STATUS, 32'h7);
		wr(ADDR_INT_CLEAR, 32'h7);
		rd("int_status", ADDR_INT_STATUS, 32'h0);
		$display("test chain done");
	endtask : t_chain

	task automatic t_preset();
		wr(ADDR_QUES_ENABLE, 32'hffff);
		wr(ADDR_INST_ENABLE, 32'hffff);
		wr(ADDR_INT_ENABLE, 32'h3);
		for (int i = 0; i < CH_COUNT; i++) begin
			wr(cha(i, CH_OFS_ENABLE), 32'h7);
		end
		rd("ques_enable", ADDR_QUES_ENABLE, 32'hffff);
		wr(ADDR_PRESET, 32'h1);
		rd("ques_enable", ADDR_QUES_ENABLE, 32'h0);
		rd("inst_enable", ADDR_INST_ENABLE, 32'h0);
		for (int i = 0; i < CH_COUNT; i++) begin
			rd("ch_enable", cha(i, CH_OFS_ENABLE), 32'h0);
		end
		rd("int_enable", ADDR_INT_ENABLE, 32'h3);
		$display("test preset done");
	endtask : t_preset

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ques_cond_in = 16'h0000;
		current_regulated_state = '0;
		voltage_regulated_state = '0;
		hw_fail = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_unmapped();
		t_irq();
		t_cond();
		t_chain();
		t_preset();
		end_of_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule : tb_questionable_status_aggregator
